// File: core/sfoi_defines.vh
// Constants for the sync filter, over-range detector and start-up status bank.
// Assumes a 12-bit register address from the configuration port.
`ifndef SFOI_DEFINES_VH
`define SFOI_DEFINES_VH

// Register byte addresses
`define SFOI_ADDR_SYNC_LIMIT 12'h210
`define SFOI_ADDR_OVR_LEVEL 12'h211
`define SFOI_ADDR_OVERRANGE_CONFIG 12'h213
`define SFOI_ADDR_STARTUP 12'h270

// Reset values
`define SFOI_RST_SYNC_LIMIT 5'h03
`define SFOI_RST_OVR_LEVEL 8'hf2
`define SFOI_RST_OVR_ENABLE 1'h0
`define SFOI_RST_OVR_EXP 3'h7

// Field positions
`define SFOI_SYNC_LIMIT_MSB 4
`define SFOI_OVR_ENABLE_BIT 3
`define SFOI_OVR_EXP_MSB 2
`define SFOI_INIT_DONE_BIT 0

// Stretch base of four sampling cycles, as a shift of two
`define SFOI_STRETCH_BASE_SHIFT 2
// Stretch counter width: 4 * 2^7 = 512 needs ten bits
`define SFOI_STRETCH_W 10
// Sync low-run counter width, one above the five-bit limit field
`define SFOI_SYNC_CNT_W 6
// Default start-up sequence length in clock cycles
`define SFOI_INIT_CYCLES 16'h0100

`endif

// File: core/sfoi_regs.v
// Sync request filter, four-channel over-range detector with pulse stretching,
// and the start-up status flag, with their registers.
// Assumes one clock per sampling cycle, inputs synchronous to clk, and a simple
// address/strobe register port behind the serial configuration interface.
// Operation
// - Low-active sync input is sampled on a link enable at half the sample rate.
// - Sync request when low on limit plus one consecutive link samples.
// - Shorter low runs are error reports and cause no action.
// - Over-range asserts when absolute sample reaches the eight-bit level, reset f2.
// - Over-range enable clear holds all four outputs low.
// - Output pulse stretched to at least four times two to the exponent cycles.
// - Start-up done bit reads zero after reset, one when start-up finishes.
`timescale 1ns/10ps
`include "sfoi_defines.vh"

module sfoi_regs #(
    parameter SAMPLE_W = 9, // Signed sample width; magnitude full scale is 256
    parameter INIT_CYCLES = `SFOI_INIT_CYCLES // Start-up sequence length
) (
    input wire clk, // 20 MHz system clock, one sampling cycle
    input wire rst, // Synchronous reset, active high
    input wire [11:0] reg_addr, // Register byte address
    input wire [7:0] reg_wdata, // Write data
    input wire reg_wr, // Write strobe, one cycle
    input wire reg_rd, // Read strobe, one cycle
    output reg [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    input wire sync_n, // Sync input from link receiver, active low
    input wire [SAMPLE_W-1:0] sample_a, // Channel A sample, two's complement
    input wire [SAMPLE_W-1:0] sample_b, // Channel B sample
    input wire [SAMPLE_W-1:0] sample_c, // Channel C sample
    input wire [SAMPLE_W-1:0] sample_d, // Channel D sample
    output reg sync_request, // One-cycle pulse per accepted sync request
    output wire overrange_out_a, // Channel A over-range status
    output wire overrange_out_b, // Channel B over-range status
    output wire overrange_out_c, // Channel C over-range status
    output wire overrange_out_d, // Channel D over-range status
    output wire init_done // Start-up sequence finished
);

    // Absolute value, widened by one bit so the most negative code is exact
    function [SAMPLE_W:0] sfoi_abs;
        input [SAMPLE_W-1:0] s;
        begin
            if (s[SAMPLE_W-1])
                sfoi_abs = {1'b0, ~s} + {{SAMPLE_W{1'b0}}, 1'b1};
            else
                sfoi_abs = {1'b0, s};
        end
    endfunction

    reg [4:0] sync_low_count_limit_reg;
    reg [7:0] overrange_level_setting_reg;
    reg overrange_output_enable_reg;
    reg [2:0] overrange_stretch_exponent_reg;
    reg init_done_reg;
    reg [15:0] init_cnt_reg;
    reg link_ce_reg;
    reg [`SFOI_SYNC_CNT_W-1:0] sync_cnt_reg;
    reg sync_fired_reg;
    reg [7:0] rdata_next;
    wire [`SFOI_STRETCH_W-1:0] stretch_len;
    wire [SAMPLE_W-1:0] samples [0:3];
    wire [3:0] ovr_out;

    assign samples[0] = sample_a;
    assign samples[1] = sample_b;
    assign samples[2] = sample_c;
    assign samples[3] = sample_d;

    // Register writes; reserved bits are dropped so they always read zero
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync_low_count_limit_reg <= `SFOI_RST_SYNC_LIMIT;
            overrange_level_setting_reg <= `SFOI_RST_OVR_LEVEL;
            overrange_output_enable_reg <= `SFOI_RST_OVR_ENABLE;
            overrange_stretch_exponent_reg <= `SFOI_RST_OVR_EXP;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SFOI_ADDR_SYNC_LIMIT:
                    sync_low_count_limit_reg <= reg_wdata[`SFOI_SYNC_LIMIT_MSB:0];
                `SFOI_ADDR_OVR_LEVEL:
                    overrange_level_setting_reg <= reg_wdata;
                `SFOI_ADDR_OVERRANGE_CONFIG:
                begin
                    overrange_output_enable_reg <= reg_wdata[`SFOI_OVR_ENABLE_BIT];
                    overrange_stretch_exponent_reg <= reg_wdata[`SFOI_OVR_EXP_MSB:0];
                end
                default:
                    sync_low_count_limit_reg <= sync_low_count_limit_reg;
            endcase
        end
    end

    // Read mux; unmapped and write-only-free addresses answer zero
    always @*
    begin
        rdata_next = 8'h00;
        case (reg_addr)
            `SFOI_ADDR_SYNC_LIMIT:
                rdata_next = {3'h0, sync_low_count_limit_reg};
            `SFOI_ADDR_OVR_LEVEL:
                rdata_next = overrange_level_setting_reg;
            `SFOI_ADDR_OVERRANGE_CONFIG:
                rdata_next = {4'h0, overrange_output_enable_reg, overrange_stretch_exponent_reg};
            `SFOI_ADDR_STARTUP:
                rdata_next = {7'h00, init_done_reg};
            default:
                rdata_next = 8'h00;
        endcase
    end

    // Read data is held until the next read so the port sees a stable byte
    always @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_next;
    end

    // Start-up sequencer: done rises after a fixed count and stays set
    always @(posedge clk)
    begin
        if (rst)
        begin
            init_cnt_reg <= 16'h0000;
            init_done_reg <= 1'b0;
        end
        else if (!init_done_reg)
        begin
            init_cnt_reg <= init_cnt_reg + 16'h0001;
            if (init_cnt_reg == INIT_CYCLES[15:0] - 16'h0001)
                init_done_reg <= 1'b1;
        end
    end

    assign init_done = init_done_reg;

    // Link clock enable: divide by two from the sampling rate
    always @(posedge clk)
    begin
        if (rst)
            link_ce_reg <= 1'b0;
        else
            link_ce_reg <= ~link_ce_reg;
    end

    // Sync low-run filter; a request fires once per run, on its limit+1 th low sample.
    // A run that ends early simply resets the count, so error reports do nothing.
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync_cnt_reg <= {`SFOI_SYNC_CNT_W{1'b0}};
            sync_fired_reg <= 1'b0;
            sync_request <= 1'b0;
        end
        else
        begin
            sync_request <= 1'b0;
            if (link_ce_reg)
            begin
                if (sync_n)
                begin
                    sync_cnt_reg <= {`SFOI_SYNC_CNT_W{1'b0}};
                    sync_fired_reg <= 1'b0;
                end
                else if (!sync_fired_reg)
                begin
                    if (sync_cnt_reg == {1'b0, sync_low_count_limit_reg})
                    begin
                        sync_request <= 1'b1;
                        sync_fired_reg <= 1'b1;
                    end
                    else
                        sync_cnt_reg <= sync_cnt_reg + {{(`SFOI_SYNC_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Minimum pulse length in sampling cycles
    assign stretch_len = {{(`SFOI_STRETCH_W-1){1'b0}}, 1'b1}
        << (overrange_stretch_exponent_reg + `SFOI_STRETCH_BASE_SHIFT);

    // Per-channel detector and stretcher
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : g_chan
            reg [`SFOI_STRETCH_W-1:0] cnt_reg;
            reg out_reg;
            wire exceed;
            // Magnitude compared on the 256-step scale of the level setting;
            // the level is widened to the magnitude's full width so no bit is lost
            assign exceed = sfoi_abs(samples[ch]) >=
                {{(SAMPLE_W-7){1'b0}}, overrange_level_setting_reg};
            always @(posedge clk)
            begin
                if (rst || !overrange_output_enable_reg)
                begin
                    cnt_reg <= {`SFOI_STRETCH_W{1'b0}};
                    out_reg <= 1'b0;
                end
                else if (exceed)
                begin
                    cnt_reg <= stretch_len;
                    out_reg <= 1'b1;
                end
                else if (cnt_reg > {{(`SFOI_STRETCH_W-1){1'b0}}, 1'b1})
                begin
                    cnt_reg <= cnt_reg - {{(`SFOI_STRETCH_W-1){1'b0}}, 1'b1};
                    out_reg <= 1'b1;
                end
                else
                begin
                    cnt_reg <= {`SFOI_STRETCH_W{1'b0}};
                    out_reg <= 1'b0;
                end
            end
            assign ovr_out[ch] = out_reg;
        end
    endgenerate

    assign overrange_out_a = ovr_out[0];
    assign overrange_out_b = ovr_out[1];
    assign overrange_out_c = ovr_out[2];
    assign overrange_out_d = ovr_out[3];

endmodule // sfoi_regs

// File: test/sfoi_regs_chk.sv
// Port checker for the sync, over-range and status bank.
// Assumes a nine-bit sample and synchronous active-high reset.
`timescale 1ns/10ps
module sfoi_regs_chk (
    input wire clk, // Clock
    input wire rst, // Reset
    input wire [11:0] reg_addr, // Address
    input wire reg_rd, // Read strobe
    input wire reg_wr, // Write strobe
    input wire [7:0] reg_rdata, // Read data
    input wire sync_n, // Sync line
    input wire sync_request, // Request pulse
    input wire overrange_out_a, // Status A
    input wire overrange_out_b, // Status B
    input wire overrange_out_c, // Status C
    input wire overrange_out_d, // Status D
    input wire init_done // Start-up done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Reads outside the four mapped bytes
    wire unmapped = reg_addr != 12'h210 && reg_addr != 12'h211
        && reg_addr != 12'h213 && reg_addr != 12'h270;
    // A write may clear the enable and cut a pulse short
    sequence s_held(o);
        (o || $past(reg_wr) || $past(reg_wr, 2))[*4];
    endsequence
    a_rst_quiet: assert property (disable iff (1'b0) rst |=> !init_done && !sync_request
        && reg_rdata == 8'h00 && !(overrange_out_a | overrange_out_b | overrange_out_c
        | overrange_out_d)) else $error("outputs not quiet after reset");
    a_init_sticky: assert property (init_done |=> init_done)
        else $error("start-up done dropped");
    a_status_read: assert property (reg_rd && reg_addr == 12'h270
        |=> reg_rdata == {7'h00, $past(init_done)}) else $error("status read wrong");
    a_unmapped_read: assert property (reg_rd && unmapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_limit_reserved: assert property (reg_rd && reg_addr == 12'h210
        |=> reg_rdata[7:5] == 3'h0) else $error("limit reserved bits set");
    a_sync_single: assert property (sync_request |=> !sync_request)
        else $error("request pulse too long");
    a_sync_low_cause: assert property (sync_request |-> !$past(sync_n))
        else $error("request without low sample");
    a_or_held_a: assert property ($rose(overrange_out_a) |-> s_held(overrange_out_a))
        else $error("channel a pulse short");
    a_or_held_d: assert property ($rose(overrange_out_d) |-> s_held(overrange_out_d))
        else $error("channel d pulse short");
endmodule // sfoi_regs_chk
bind sfoi_regs sfoi_regs_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .sync_n(sync_n),
    .sync_request(sync_request), .overrange_out_a(overrange_out_a),
    .overrange_out_b(overrange_out_b), .overrange_out_c(overrange_out_c),
    .overrange_out_d(overrange_out_d), .init_done(init_done));

// File: test/sfoi_sync_src.sv
// Link receiver model driving the low-active sync line.
// Assumes the bench pulses go for one cycle with run_len in cycles.
`timescale 1ns/10ps
module sfoi_sync_src (
    input wire clk, // System clock
    input wire go, // Start a low run
    input wire [7:0] run_len, // Low run length
    output logic sync_n // Sync to the device
);
    int left = 0;
    initial sync_n = 1'b1;
    // No sync word is sent here; the model only drives the level of the sync_n line
    // Idle high between runs: low runs of any nonzero run_len are sent, short ones acting as error reports
    always @(posedge clk)
    begin
        if (go)
            left = run_len;
        sync_n <= !(left > 0);
        if (left > 0)
            left--;
    end
endmodule // sfoi_sync_src

// File: test/testbench.sv
// Self-checking bench for the sync, over-range and status bank.
// Assumes a short start-up of four cycles and a nine-bit sample.
`timescale 1ns/10ps
module testbench;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0;
    logic [11:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, run_len = 0;
    logic [8:0] sample_a = 0, sample_b = 0, sample_c = 0, sample_d = 0;
    wire [7:0] reg_rdata;
    wire sync_n, sync_request, or_a, or_b, or_c, or_d, init_done;
    int error_cnt = 0, num_checks = 0, pulse_cnt = 0;
    int oc [4];
    always #25 clk = ~clk;
    sfoi_regs #(.SAMPLE_W(9), .INIT_CYCLES(4)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_n(sync_n), .sample_a(sample_a), .sample_b(sample_b), .sample_c(sample_c),
        .sample_d(sample_d), .sync_request(sync_request), .overrange_out_a(or_a),
        .overrange_out_b(or_b), .overrange_out_c(or_c), .overrange_out_d(or_d),
        .init_done(init_done));
    sfoi_sync_src partner (.clk(clk), .go(go), .run_len(run_len), .sync_n(sync_n));
    // Count request pulses and high cycles of each status output
    always @(posedge clk)
    begin
        pulse_cnt += (sync_request === 1'b1);
        oc[0] += (or_a === 1'b1);
        oc[1] += (or_b === 1'b1);
        oc[2] += (or_c === 1'b1);
        oc[3] += (or_d === 1'b1);
    end
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk);
        reg_wr = 0;
    endtask
    task rchk(input string what, input logic [11:0] a, input logic [7:0] e);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        reg_rd = 0;
        chk(what, e, reg_rdata);
    endtask
    // Host touches nothing but the done flag until start-up ends
    task t_regs;
        chk("init_done", 0, init_done);
        repeat (20) if (init_done !== 1'b1) @(negedge clk);
        chk("init_done", 1, init_done);
        rchk("status", 12'h270, 8'h01);
        rchk("limit", 12'h210, 8'h03);
        rchk("level", 12'h211, 8'hf2);
        rchk("cfg", 12'h213, 8'h07);
        rchk("unmapped", 12'h212, 8'h00);
        wr(12'h270, 8'h00);
        rchk("status", 12'h270, 8'h01);
        wr(12'h210, 8'h1f);
        rchk("limit", 12'h210, 8'h1f);
        $display("test regs done");
    endtask
    // Low runs just short of and just over limit plus one samples
    task t_sync;
        logic [7:0] tl [5] = '{0, 2, 2, 1, 1};
        logic [7:0] tn [5] = '{4, 3, 8, 1, 5};
        int te [5] = '{1, 0, 1, 0, 1};
        for (int i = 0; i < 5; i++)
        begin
            wr(12'h210, tl[i]);
            pulse_cnt = 0;
            @(negedge clk);
            {run_len, go} = {tn[i], 1'b1};
            @(negedge clk);
            go = 0;
            repeat (tn[i] + 8) @(negedge clk);
            chk("sync pulses", te[i], pulse_cnt);
        end
        $display("test sync done");
    endtask
    task ovr(input logic [7:0] cfg, input int hits, input int e);
        wr(12'h213, cfg);
        oc = '{0, 0, 0, 0};
        repeat (hits)
        begin
            @(negedge clk);
            {sample_a, sample_b, sample_c, sample_d} = {9'h1f0, 9'h00f, 9'h010, 9'h100};
            @(negedge clk);
            {sample_a, sample_b, sample_c, sample_d} = 36'h0;
        end
        repeat (20) @(negedge clk);
        chk("or a", e, oc[0]);
        chk("or b", 0, oc[1]);
        chk("or c", e, oc[2]);
        chk("or d", e, oc[3]);
    endtask
    task t_ovr;
        wr(12'h211, 8'h10);
        ovr(8'h08, 1, 4);
        ovr(8'h08, 2, 6);
        ovr(8'h09, 1, 8);
        ovr(8'h01, 1, 0);
        $display("test ovr done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 0;
        t_regs;
        t_sync;
        t_ovr;
        final_report;
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #200000;
        error_cnt++;
        $display("watchdog expired");
        final_report;
    end
endmodule // testbench
